// File: afd_chan.v
/*
 * One channel of permanent diagnostics: overload recheck, diagnostic
 * cycle, restart mode and latched permanent-fault result.
 * Assumes a shared 1 us tick and synchronised fault inputs.
 */
`timescale 1ns/1ps
`include "afd_defs.vh"

module afd_chan #(
  parameter RECHECK_TICKS = `AFD_RECHECK_US,
  parameter CYCLE_TICKS   = `AFD_CYCLE_US
) (
  input  wire                 clk,
  input  wire                 srst,
  input  wire                 tick,
  input  wire                 diag_en,
  input  wire                 rearm,
  input  wire                 overload,
  input  wire [`AFD_FW-1:0]   fault_now,
  output reg                  shut,
  output reg                  done,
  output reg                  busy,
  output reg  [`AFD_FW-1:0]   result
);

  localparam [3:0] S_ACTIVE  = 4'h1;
  localparam [3:0] S_RECHECK = 4'h2;
  localparam [3:0] S_CYCLE   = 4'h4;
  localparam [3:0] S_RESTART = 4'h8;

  reg [3:0]             state;
  reg [`AFD_TIME_W-1:0] tcnt;
  reg [`AFD_FW-1:0]     stable;

  // Open load is never a permanent fault
  wire [`AFD_FW-1:0] perm_fault = fault_now & 5'h0F;

  always @(posedge clk) begin
    if (srst) begin
      state  <= S_ACTIVE;
      tcnt   <= {`AFD_TIME_W{1'b0}};
      shut   <= 1'b0;
      done   <= 1'b0;
      busy   <= 1'b0;
      result <= `AFD_RST_FAULT;
      stable <= `AFD_RST_FAULT;
    end else begin
      if (rearm)
        done <= 1'b0;
      case (state)
        S_ACTIVE: begin
          shut <= 1'b0;
          busy <= 1'b0;
          if (overload) begin
            shut  <= 1'b1;
            tcnt  <= {`AFD_TIME_W{1'b0}};
            if (diag_en && !done && !rearm) begin
              state <= S_RECHECK;
              busy  <= 1'b1;
            end else begin
              state <= S_RESTART;
            end
          end
        end
        S_RECHECK: begin
          if (tick)
            tcnt <= tcnt + 1'b1;
          if (tick && tcnt == RECHECK_TICKS - 1) begin
            tcnt <= {`AFD_TIME_W{1'b0}};
            if (overload) begin
              state  <= S_CYCLE;
              stable <= perm_fault;
            end else begin
              state <= S_ACTIVE;
              shut  <= 1'b0;
              busy  <= 1'b0;
            end
          end
        end
        S_CYCLE: begin
          stable <= stable & perm_fault;
          if (tick)
            tcnt <= tcnt + 1'b1;
          if (tick && tcnt == CYCLE_TICKS - 1) begin
            result <= stable & perm_fault;
            done   <= 1'b1;
            busy   <= 1'b0;
            tcnt   <= {`AFD_TIME_W{1'b0}};
            state  <= S_RESTART;
          end
        end
        S_RESTART: begin
          shut <= 1'b1;
          if (tick)
            tcnt <= tcnt + 1'b1;
          if (tick && tcnt == RECHECK_TICKS - 1) begin
            tcnt <= {`AFD_TIME_W{1'b0}};
            if (!overload) begin
              state <= S_ACTIVE;
              shut  <= 1'b0;
            end
          end
        end
        default: state <= S_ACTIVE;
      endcase
    end
  end

endmodule

// File: afd_defs.vh
/*
 * Constants for the amplifier output-fault diagnostic sequencer.
 * Assumes a 200 MHz clock; all timing derives from a 1 us tick.
 */
`ifndef AFD_DEFS_VH
`define AFD_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define AFD_CLK_MHZ          200
`define AFD_TICK_US          1
`define AFD_TICK_CYC         (`AFD_CLK_MHZ * `AFD_TICK_US)
`define AFD_RECHECK_US       1000
`define AFD_CYCLE_US         100000
`define AFD_ACQ_US           100000
`define AFD_TICK_W           8
`define AFD_TIME_W           17

// ----------------------------------------
// Fault code field positions (per channel, 5 bits)
// ----------------------------------------
`define AFD_F_GND_SO         0
`define AFD_F_GND_SK         1
`define AFD_F_VS             2
`define AFD_F_SHORT          3
`define AFD_F_OPEN           4
`define AFD_FW               5

// ----------------------------------------
// Misc
// ----------------------------------------
`define AFD_AC_PULSES        3
`define AFD_PCNT_W           2
`define AFD_RST_FAULT        5'h00

`endif

// File: afd_host_model.sv
/* Host side model: instruction levels, read pulses and a test tone.
   Assumes the bench calls its tasks; all changes on the falling edge. */
`timescale 1ns/1ps

module afd_host_model (
  input  wire       clk,
  output reg        host_read,
  output reg        diag_enable,
  output reg        offset_enable_bit,
  output reg        current_detect_enable_bit,
  output reg        standby_off,
  output reg        line_driver_mode,
  output reg  [3:0] gain_16db,
  output reg  [3:0] cur_hi_pin
);
  initial begin
    host_read = 1'b0;
    {diag_enable, offset_enable_bit, current_detect_enable_bit} = 3'h0;
    {standby_off, line_driver_mode} = 2'h0;
    gain_16db = 4'h0;
    cur_hi_pin = 4'h0;
  end

  task automatic write_bytes(input logic [4:0] c, input logic [3:0] g);
    @(negedge clk);
    {diag_enable, offset_enable_bit, current_detect_enable_bit} = c[4:2];
    {standby_off, line_driver_mode} = c[1:0];
    gain_16db = g;
  endtask

  task automatic read_bus;
    @(negedge clk);
    host_read = 1'b1;
    @(negedge clk);
    host_read = 1'b0;
    @(negedge clk);
  endtask

  task automatic tone(input logic [3:0] m, input int n);
    repeat (n) begin
      @(negedge clk);
      cur_hi_pin = m;
      repeat (4) @(negedge clk);
      cur_hi_pin = 4'h0;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

// File: afd_top.v
/*
 * Output-fault diagnostic sequencer for a four-channel power amplifier.
 * Holds the turn-on pulse diagnostic, permanent diagnostics per
 * channel, DC offset window, AC tweeter current count and the
 * double-fault priority that shapes the reported result.
 * Assumes the serial bus slave decodes instruction bytes into the
 * level control ports and gives a one-cycle host_read pulse per read.
 * Analog comparator outputs arrive asynchronously and are synchronised.
 */
// Contract
// - Turn-on diagnostic on standby exit when requested
// - Turn-on result held until next read
// - Pulse before bias; outputs stay high impedance
// - Then permanent; keep turn-on until short
// - Capture at pulse top end, ~100 ms
// - Same ground/supply thresholds at both gains
// - Line-driver load thresholds only at 16 dB
// - Permanent: shorts and offset, never open load
// - Restart mode: channel alone shuts, 1 ms recheck
// - Diagnostic armed by enable, started by overload
// - Recheck at 1 ms, clear returns active
// - Persistent overload runs ~100 ms cycle
// - Cycle end: restart mode, store fault
// - Next cycle only after host read
// - Flag DC offset beyond two volts
// - Offset window from read or enable rise
// - Overload suppresses offset and AC diagnostic
// - Current above 500 normal, below 250 open
// - Fewer than three pulses means open tweeter
// - Multiple faults reported over successive reads (code reports only the priority result)
// - Double faults reported by fixed priority
// - Read returns previous cycle, then re-arms
// - Report only faults stable whole period
`timescale 1ns/1ps
`include "afd_defs.vh"

module afd_top #(
  parameter CHANNELS      = 4,
  parameter RECHECK_TICKS = `AFD_RECHECK_US,
  parameter CYCLE_TICKS   = `AFD_CYCLE_US,
  parameter ACQ_TICKS     = `AFD_ACQ_US
) (
  input  wire                          clk,
  input  wire                          srst,
  input  wire                          host_read,
  input  wire                          diag_enable,
  input  wire                          offset_enable_bit,
  input  wire                          current_detect_enable_bit,
  input  wire                          standby_off,
  input  wire                          line_driver_mode,
  input  wire [CHANNELS-1:0]           gain_16db,
  input  wire [CHANNELS-1:0]           ovl_pin,
  input  wire [CHANNELS*`AFD_FW-1:0]   fault_pin,
  input  wire [CHANNELS-1:0]           offset_pin,
  input  wire [CHANNELS-1:0]           cur_hi_pin,
  output reg                           stage_biased,
  output reg                           outputs_hiz,
  output reg                           pulse_active,
  output reg                           turnon_done,
  output reg                           perm_mode,
  output reg  [CHANNELS-1:0]           line_thresh_sel,
  output reg  [CHANNELS-1:0]           chan_shut,
  output reg  [CHANNELS-1:0]           cycle_done,
  output reg  [CHANNELS*`AFD_FW-1:0]   fault_report,
  output reg  [CHANNELS-1:0]           offset_flag,
  output reg  [CHANNELS-1:0]           open_tweeter
);

  // ----------------------------------------
  // Priority encoding of double faults
  // ----------------------------------------
  function [`AFD_FW-1:0] prio;
    input [`AFD_FW-1:0] f;
    input               allow_open;
    reg   [`AFD_FW-1:0] o;
    begin
      o = f;
      if (!allow_open)
        o[`AFD_F_OPEN] = 1'b0;
      if (o[`AFD_F_VS]) begin
        o = {`AFD_FW{1'b0}};
        o[`AFD_F_VS]     = 1'b1;
        o[`AFD_F_GND_SO] = f[`AFD_F_GND_SO];
      end else if (o[`AFD_F_GND_SO]) begin
        o = {`AFD_FW{1'b0}};
        o[`AFD_F_GND_SO] = 1'b1;
      end else if (o[`AFD_F_GND_SK]) begin
        if (o[`AFD_F_OPEN]) begin
          o = {`AFD_FW{1'b0}};
          o[`AFD_F_OPEN] = 1'b1;
        end else begin
          o = {`AFD_FW{1'b0}};
          o[`AFD_F_GND_SK] = 1'b1;
        end
      end else if (o[`AFD_F_SHORT]) begin
        o[`AFD_F_OPEN] = 1'b0;
      end
      prio = o;
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam SW = CHANNELS * (3 + `AFD_FW);
  reg [SW-1:0] sync1;
  reg [SW-1:0] sync2;
  always @(posedge clk) begin
    if (srst) begin
      sync1 <= {SW{1'b0}};
      sync2 <= {SW{1'b0}};
    end else begin
      sync1 <= {ovl_pin, offset_pin, cur_hi_pin, fault_pin};
      sync2 <= sync1;
    end
  end
  wire [CHANNELS-1:0]         ovl;
  wire [CHANNELS-1:0]         offs;
  wire [CHANNELS-1:0]         cur_hi;
  wire [CHANNELS*`AFD_FW-1:0] flt;
  assign {ovl, offs, cur_hi, flt} = sync2;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // internal tick counter
  reg [`AFD_TICK_W-1:0] tdiv;
  reg                   tick;
  always @(posedge clk) begin
    if (srst) begin
      tdiv <= {`AFD_TICK_W{1'b0}};
      tick <= 1'b0;
    end else if (tdiv == `AFD_TICK_CYC - 1) begin
      tdiv <= {`AFD_TICK_W{1'b0}};
      tick <= 1'b1;
    end else begin
      tdiv <= tdiv + 1'b1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Turn-on sequencer
  // ----------------------------------------
  localparam [3:0] T_STBY  = 4'h1;
  localparam [3:0] T_PULSE = 4'h2;
  localparam [3:0] T_BIAS  = 4'h4;
  localparam [3:0] T_WAIT  = 4'h8;

  reg [3:0]                   tstate;
  reg [`AFD_TIME_W-1:0]       acq_cnt;
  reg                         turnon_req;
  reg [CHANNELS*`AFD_FW-1:0]  ton_stable;
  reg [CHANNELS*`AFD_FW-1:0]  ton_result;
  reg [CHANNELS-1:0]          ton_valid;
  wire                        acq_end = tick && acq_cnt == ACQ_TICKS - 1;

  always @(posedge clk) begin
    if (srst) begin
      tstate       <= T_STBY;
      acq_cnt      <= {`AFD_TIME_W{1'b0}};
      turnon_req   <= 1'b1;
      ton_stable   <= {CHANNELS*`AFD_FW{1'b0}};
      ton_result   <= {CHANNELS*`AFD_FW{1'b0}};
      stage_biased <= 1'b0;
      outputs_hiz  <= 1'b1;
      pulse_active <= 1'b0;
      turnon_done  <= 1'b0;
      perm_mode    <= 1'b0;
    end else begin
      if (host_read)
        turnon_req <= 1'b1;
      case (tstate)
        T_STBY: begin
          stage_biased <= 1'b0;
          outputs_hiz  <= 1'b1;
          perm_mode    <= 1'b0;
          if (standby_off) begin
            if (diag_enable && turnon_req) begin
              tstate       <= T_PULSE;
              pulse_active <= 1'b1;
              acq_cnt      <= {`AFD_TIME_W{1'b0}};
              ton_stable   <= flt;
            end else begin
              tstate <= T_BIAS;
            end
          end
        end
        T_PULSE: begin
          ton_stable <= ton_stable & flt;
          if (tick)
            acq_cnt <= acq_cnt + 1'b1;
          if (acq_end) begin
            ton_result   <= ton_stable & flt;
            turnon_done  <= 1'b1;
            turnon_req   <= host_read;
            pulse_active <= 1'b0;
            tstate       <= T_BIAS;
          end
          if (!standby_off) begin
            pulse_active <= 1'b0;
            tstate       <= T_STBY;
          end
        end
        T_BIAS: begin
          stage_biased <= 1'b1;
          outputs_hiz  <= 1'b0;
          perm_mode    <= 1'b1;
          tstate       <= T_WAIT;
        end
        T_WAIT: begin
          if (!standby_off)
            tstate <= T_STBY;
        end
        default: tstate <= T_STBY;
      endcase
    end
  end

  // ----------------------------------------
  // Per-channel permanent diagnostics
  // ----------------------------------------
  wire [CHANNELS-1:0]         ch_shut;
  wire [CHANNELS-1:0]         ch_done;
  wire [CHANNELS-1:0]         ch_busy;
  wire [CHANNELS*`AFD_FW-1:0] ch_res;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gch
      afd_chan #(
        .RECHECK_TICKS (RECHECK_TICKS),
        .CYCLE_TICKS   (CYCLE_TICKS)
      ) u_chan (
        .clk       (clk),
        .srst      (srst),
        .tick      (tick),
        .diag_en   (diag_enable),
        .rearm     (host_read),
        .overload  (ovl[g] & perm_mode),
        .fault_now (flt[g*`AFD_FW +: `AFD_FW]),
        .shut      (ch_shut[g]),
        .done      (ch_done[g]),
        .busy      (ch_busy[g]),
        .result    (ch_res[g*`AFD_FW +: `AFD_FW])
      );
    end
  endgenerate

  // ----------------------------------------
  // Offset window and AC current count
  // ----------------------------------------
  reg [CHANNELS-1:0]        offs_hold;
  reg [CHANNELS-1:0]        ovl_seen;
  reg [`AFD_PCNT_W-1:0]     pcnt [0:CHANNELS-1];
  reg [CHANNELS-1:0]        cur_prev;
  reg                       offen_prev;
  reg                       curen_prev;
  wire                      off_start = host_read | (offset_enable_bit & ~offen_prev);
  wire                      cur_start = host_read | (current_detect_enable_bit & ~curen_prev);
  integer i;

  always @(posedge clk) begin
    if (srst) begin
      offs_hold  <= {CHANNELS{1'b0}};
      ovl_seen   <= {CHANNELS{1'b0}};
      cur_prev   <= {CHANNELS{1'b0}};
      offen_prev <= 1'b0;
      curen_prev <= 1'b0;
      for (i = 0; i < CHANNELS; i = i + 1)
        pcnt[i] <= {`AFD_PCNT_W{1'b0}};
    end else begin
      offen_prev <= offset_enable_bit;
      curen_prev <= current_detect_enable_bit;
      cur_prev   <= cur_hi;
      for (i = 0; i < CHANNELS; i = i + 1) begin
        // window opens at read or enable
        if (off_start)
          offs_hold[i] <= 1'b1;
        else if (!offs[i])
          offs_hold[i] <= 1'b0;
        if (off_start || cur_start)
          ovl_seen[i] <= 1'b0;
        else if (ovl[i])
          ovl_seen[i] <= 1'b1;
        if (cur_start)
          pcnt[i] <= {`AFD_PCNT_W{1'b0}};
        else if (cur_hi[i] && !cur_prev[i] && pcnt[i] != `AFD_AC_PULSES)
          pcnt[i] <= pcnt[i] + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Reported code per channel
  // ----------------------------------------
  reg [CHANNELS*`AFD_FW-1:0] next_report;
  integer j;
  always @* begin
    next_report = {CHANNELS*`AFD_FW{1'b0}};
    for (j = 0; j < CHANNELS; j = j + 1) begin
      // one fault by priority; an AFD_F_VS fault keeps AFD_F_GND_SO too
      if (ch_done[j])
        next_report[j*`AFD_FW +: `AFD_FW] = prio(ch_res[j*`AFD_FW +: `AFD_FW], 1'b0);
      else if (ton_valid[j])
        next_report[j*`AFD_FW +: `AFD_FW] = prio(ton_result[j*`AFD_FW +: `AFD_FW], 1'b1);
    end
  end

  // ----------------------------------------
  // Result latch on host read
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      line_thresh_sel <= {CHANNELS{1'b0}};
      chan_shut       <= {CHANNELS{1'b0}};
      cycle_done      <= {CHANNELS{1'b0}};
      fault_report    <= {CHANNELS*`AFD_FW{1'b0}};
      offset_flag     <= {CHANNELS{1'b0}};
      open_tweeter    <= {CHANNELS{1'b0}};
      ton_valid       <= {CHANNELS{1'b1}};
    end else begin
      // line-driver set only at 16 dB
      line_thresh_sel <= gain_16db & {CHANNELS{line_driver_mode}};
      chan_shut       <= ch_shut;
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (ch_busy[i])
          ton_valid[i] <= 1'b0;
        else if (acq_end && tstate == T_PULSE)
          ton_valid[i] <= 1'b1;
      end
      if (host_read) begin
        cycle_done   <= ch_done;
        fault_report <= next_report;
        for (i = 0; i < CHANNELS; i = i + 1) begin
          offset_flag[i]  <= offs_hold[i] & offs[i] & ~ovl_seen[i] & perm_mode;
          open_tweeter[i] <= current_detect_enable_bit & ~ovl_seen[i] &
                             (pcnt[i] != `AFD_AC_PULSES);
        end
      end
    end
  end

endmodule

// File: afd_top_assertions.sv
/* Port checker for afd_top: turn-on pulse, result hold, threshold set.
   Assumes a 200-cycle tick and the shortened turn-on count. */
`timescale 1ns/1ps
`include "afd_defs.vh"

module afd_top_assertions #(
  parameter CHANNELS  = 4,
  parameter ACQ_TICKS = 10
) (
  input wire                        clk,
  input wire                        srst,
  input wire                        host_read,
  input wire                        diag_enable,
  input wire                        current_detect_enable_bit,
  input wire                        standby_off,
  input wire                        line_driver_mode,
  input wire [CHANNELS-1:0]         gain_16db,
  input wire                        stage_biased,
  input wire                        outputs_hiz,
  input wire                        pulse_active,
  input wire                        turnon_done,
  input wire [CHANNELS-1:0]         line_thresh_sel,
  input wire [CHANNELS-1:0]         cycle_done,
  input wire [CHANNELS*`AFD_FW-1:0] fault_report,
  input wire [CHANNELS-1:0]         offset_flag,
  input wire [CHANNELS-1:0]         open_tweeter
);
  localparam int LO = (ACQ_TICKS - 1) * 200;
  localparam int HI = (ACQ_TICKS + 1) * 200 + 8;
  int                  plen;
  logic [CHANNELS-1:0] open_bit;

  always @(posedge clk)
    if (srst || !pulse_active) plen <= 0;
    else plen <= plen + 1;

  always_comb
    for (int i = 0; i < CHANNELS; i++) open_bit[i] = fault_report[i*`AFD_FW+`AFD_F_OPEN];

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_pulse_end;
    $fell(pulse_active) && !$past(srst);
  endsequence
  sequence s_quiet;
    !host_read && !$past(host_read);
  endsequence
  sequence s_read_off;
    host_read && !current_detect_enable_bit ##2 1'b1;
  endsequence

  a_pulse_hiz: assert property (
    pulse_active |-> outputs_hiz && !stage_biased) else $error("stage left standby in pulse");
  a_pulse_cause: assert property (
    $rose(pulse_active) |-> diag_enable && standby_off) else $error("pulse without request");
  a_pulse_length: assert property (
    s_pulse_end |-> plen >= LO && plen <= HI) else $error("pulse length wrong");
  a_bias_after: assert property (
    s_pulse_end |-> ##[0:2] stage_biased) else $error("no bias after pulse");
  a_turnon_done: assert property (
    s_pulse_end |-> ##[0:2] turnon_done) else $error("turn-on capture not flagged");
  a_bias_active: assert property (
    stage_biased |-> !outputs_hiz) else $error("biased stage left high impedance");
  a_results_stand: assert property (
    s_quiet |=> $stable(fault_report) && $stable(cycle_done) && $stable(offset_flag)
      && $stable(open_tweeter)) else $error("results changed without read");
  a_perm_no_open: assert property (
    (cycle_done & open_bit) == '0) else $error("open load in permanent result");
  a_tweeter_off: assert property (
    s_read_off |-> open_tweeter == '0) else $error("open tweeter while detection off");
  a_line_select: assert property (
    $stable(gain_16db) && $stable(line_driver_mode)
      |-> line_thresh_sel == (gain_16db & {CHANNELS{line_driver_mode}}))
      else $error("threshold set wrong");
endmodule

bind afd_top afd_top_assertions #(.CHANNELS(CHANNELS), .ACQ_TICKS(ACQ_TICKS)) i_afd_chk (
  .clk, .srst, .host_read, .diag_enable, .current_detect_enable_bit, .standby_off,
  .line_driver_mode, .gain_16db, .stage_biased, .outputs_hiz, .pulse_active, .turnon_done,
  .line_thresh_sel, .cycle_done, .fault_report, .offset_flag, .open_tweeter
);

// File: testbench.sv
/* Self-checking bench for afd_top with shortened counts.
   Assumes afd_host_model as host and the bound port checker. */
`timescale 1ns/1ps

module testbench;
  typedef struct packed {logic ldm; logic [3:0] gain; logic [4:0] flt, code;} afd_row_t;

  logic        clk;
  logic        srst;
  logic [3:0]  ovl_pin;
  logic [3:0]  offset_pin;
  logic [19:0] fault_pin;
  wire         host_read, diag_enable, offset_enable_bit, current_detect_enable_bit;
  wire         standby_off, line_driver_mode;
  wire  [3:0]  gain_16db, cur_hi_pin;
  wire         stage_biased, outputs_hiz, pulse_active, turnon_done, perm_mode;
  wire  [3:0]  line_thresh_sel, chan_shut, cycle_done, offset_flag, open_tweeter;
  wire  [19:0] fault_report;
  int          fails, cmp_count, n;
  afd_row_t    rows [9];

  afd_host_model i_afd_host_model (.clk, .host_read, .diag_enable, .offset_enable_bit,
    .current_detect_enable_bit, .standby_off, .line_driver_mode, .gain_16db, .cur_hi_pin);

  afd_top #(.RECHECK_TICKS(3), .CYCLE_TICKS(10), .ACQ_TICKS(10)) i_afd_top (
    .clk, .srst, .host_read, .diag_enable, .offset_enable_bit, .current_detect_enable_bit,
    .standby_off, .line_driver_mode, .gain_16db, .ovl_pin, .fault_pin, .offset_pin,
    .cur_hi_pin, .stage_biased, .outputs_hiz, .pulse_active, .turnon_done, .perm_mode,
    .line_thresh_sel, .chan_shut, .cycle_done, .fault_report, .offset_flag, .open_tweeter);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_pulse(input logic lvl, input int lim);
    n = 0;
    while (pulse_active !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(pulse_active, lvl);
  endtask

  task automatic power_up(input logic ldm, input logic [3:0] g);
    i_afd_host_model.write_bytes({4'h9, ldm}, g);
    wait_pulse(1'b1, 20);
    cyc(500);
    chk({pulse_active, outputs_hiz, stage_biased}, 3'h6);
    wait_pulse(1'b0, 2600);
    cyc(10);
  endtask

  task close_out;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #450000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    close_out;
  end

  initial begin
    srst = 1'b1;
    ovl_pin = 4'h0;
    offset_pin = 4'h0;
    fault_pin = 20'h00000;
    rows = '{'{1'b0, 4'h0, 5'h00, 5'h00}, '{1'b1, 4'hF, 5'h05, 5'h05},
             '{1'b1, 4'h3, 5'h06, 5'h04}, '{1'b0, 4'hF, 5'h12, 5'h10},
             '{1'b1, 4'hC, 5'h11, 5'h01}, '{1'b0, 4'h5, 5'h0C, 5'h04},
             '{1'b1, 4'hA, 5'h09, 5'h01}, '{1'b0, 4'h0, 5'h10, 5'h10},
             '{1'b1, 4'h6, 5'h0A, 5'h02}};
    cyc(12);
    srst = 1'b0;
    cyc(2);
    chk({outputs_hiz, stage_biased, pulse_active, perm_mode, turnon_done}, 5'h10);
    chk(fault_report, 20'h00000);
    $display("test reset done");
    i_afd_host_model.write_bytes(5'h02, 4'h0);
    cyc(5);
    chk({pulse_active, stage_biased}, 2'h1);
    $display("test plain turn-on done");
    foreach (rows[k]) begin
      fault_pin = {4{rows[k].flt}};
      i_afd_host_model.write_bytes({4'h8, rows[k].ldm}, rows[k].gain);
      cyc(5);
      i_afd_host_model.read_bus;
      power_up(rows[k].ldm, rows[k].gain);
      chk(line_thresh_sel, rows[k].gain & {4{rows[k].ldm}});
      i_afd_host_model.read_bus;
      chk(fault_report, {4{rows[k].code}});
      $display("row %0d done", k);
    end
    fault_pin = 20'h00000;
    i_afd_host_model.write_bytes(5'h10, 4'h0);
    cyc(5);
    power_up(1'b0, 4'h0);
    i_afd_host_model.write_bytes(5'h10, 4'h0);
    cyc(5);
    i_afd_host_model.write_bytes(5'h12, 4'h0);
    cyc(20);
    chk({pulse_active, stage_biased}, 2'h1);
    $display("test no repeat pulse done");
    fault_pin = 20'h00080;
    ovl_pin = 4'h2;
    cyc(100);
    ovl_pin = 4'h0;
    cyc(1000);
    chk(chan_shut, 4'h0);
    i_afd_host_model.read_bus;
    i_afd_host_model.read_bus;
    chk(cycle_done, 4'h0);
    ovl_pin = 4'h2;
    cyc(3400);
    chk(chan_shut, 4'h2);
    i_afd_host_model.read_bus;
    chk(cycle_done, 4'h2);
    chk(fault_report[9:5], 5'h04);
    i_afd_host_model.read_bus;
    chk(cycle_done, 4'h0);
    ovl_pin = 4'h0;
    cyc(1600);
    chk(chan_shut, 4'h0);
    $display("test overload done");
    fault_pin = 20'h00000;
    offset_pin = 4'h4;
    cyc(5);
    i_afd_host_model.write_bytes(5'h1A, 4'h0);
    cyc(300);
    i_afd_host_model.read_bus;
    chk(offset_flag, 4'h4);
    offset_pin = 4'h0;
    cyc(20);
    offset_pin = 4'h4;
    cyc(300);
    i_afd_host_model.read_bus;
    chk(offset_flag, 4'h0);
    ovl_pin = 4'h4;
    cyc(50);
    ovl_pin = 4'h0;
    cyc(1000);
    i_afd_host_model.read_bus;
    chk(offset_flag, 4'h0);
    cyc(300);
    i_afd_host_model.read_bus;
    chk(offset_flag, 4'h4);
    $display("test offset done");
    offset_pin = 4'h0;
    i_afd_host_model.write_bytes(5'h16, 4'h0);
    cyc(10);
    i_afd_host_model.tone(4'h9, 2);
    i_afd_host_model.tone(4'h8, 1);
    cyc(10);
    i_afd_host_model.read_bus;
    chk(open_tweeter, 4'h7);
    i_afd_host_model.write_bytes(5'h12, 4'h0);
    i_afd_host_model.read_bus;
    chk(open_tweeter, 4'h0);
    $display("test tweeter done");
    close_out;
  end
endmodule
